// >>> src/fds_pkg.sv
// Constants, register map and types of the flow status diagnostics block
package fds_pkg;
  // Time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_MS = 1000;
  localparam int MS_CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_DEV_COND = 8'h00;
  localparam logic [7:0] OFF_WARN_COND = 8'h04;
  localparam logic [7:0] OFF_ALARM_ACT = 8'h08;
  localparam logic [7:0] OFF_ERROR_ACT = 8'h0C;
  localparam logic [7:0] OFF_ALARM_MASK = 8'h10;
  localparam logic [7:0] OFF_WARN_MASK = 8'h14;
  localparam logic [7:0] OFF_LOWER_TRIP = 8'h18;
  localparam logic [7:0] OFF_UPPER_TRIP = 8'h1C;
  localparam logic [7:0] OFF_FLOW_HYST = 8'h20;
  localparam logic [7:0] OFF_FLOW_SETTLE = 8'h24;
  localparam logic [7:0] OFF_ZREC_TIME = 8'h28;
  localparam logic [7:0] OFF_ZTOL_SETTLE = 8'h2C;
  localparam logic [7:0] OFF_ZTOL_BAND = 8'h30;
  localparam logic [7:0] OFF_CHOKE_LIM = 8'h34;
  localparam logic [7:0] OFF_CHOKE_SETTLE = 8'h38;
  localparam logic [7:0] OFF_VALVE_MAX = 8'h3C;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_RAMP_TIME = 8'h44;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h48;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h4C;

  // Reset values
  localparam logic [31:0] MASK_RST = 32'hFFFFFFFF;
  localparam logic [15:0] CFG16_RST = 16'h0000;
  localparam logic [15:0] VALVE_MAX_RST = 16'hFFFF;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // Device condition word bits
  localparam int DS_FLOW_VALID = 1;
  localparam int DS_TEMP_VALID = 2;
  localparam int DS_ZEROING = 3;
  localparam int DS_ZERO_REC = 4;
  localparam int DS_ZERO_BLOCKED = 5;
  localparam int DS_VALVE_OVR = 6;
  localparam int DS_CTRL_OVR = 7;
  localparam int DS_ERROR = 8;
  localparam int DS_ALARM = 9;
  localparam int DS_WARNING = 10;
  localparam int DS_BTN_DIS = 11;
  localparam int DS_RAMPING = 12;

  // Warning, alarm and control bits
  localparam int WN_LOW_FLOW = 0;
  localparam int WN_HIGH_FLOW = 1;
  localparam int WN_CHOKED = 3;
  localparam int WN_ZERO_DRIFT = 4;
  localparam int WN_BAD_ZERO = 5;
  localparam int AL_CHOKED = 3;
  localparam int CTRL_BTN_DIS = 0;

  // Choked flow fractions: valve 70 %, time 30 %
  localparam int CHOKE_VALVE_NUM = 7;
  localparam int CHOKE_TIME_NUM = 3;
  localparam int CHOKE_DEN = 10;
  localparam int CHOKE_LIM_FRAC = 8;

  // Settle qualifier slots
  localparam int Q_LOW_SET = 0;
  localparam int Q_LOW_CLR = 1;
  localparam int Q_HIGH_SET = 2;
  localparam int Q_HIGH_CLR = 3;
  localparam int Q_CHOKE = 4;
  localparam int Q_ZERO_SP = 5;
  localparam int NUM_Q = 6;

  // Interrupt status bits
  localparam int IRQ_LOW = 0;
  localparam int IRQ_HIGH = 1;
  localparam int IRQ_CHOKE = 2;
  localparam int IRQ_ZREC = 3;

  typedef enum logic [1:0] {
    VO_NORMAL = 2'h0,
    VO_OFF = 2'h1,
    VO_PURGE = 2'h2,
    VO_CLOSED = 2'h3
  } fds_valve_type;

  typedef enum logic [1:0] {
    CO_NORMAL = 2'h0,
    CO_OFF = 2'h1,
    CO_PURGE = 2'h2,
    CO_FIXED = 2'h3
  } fds_ctrl_type;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'h0,
    RAMP_MOVING = 2'h1
  } fds_ramp_type;
endpackage

// >>> src/fds_qual_if.sv
// Link between the status core and one settling-time qualifier
`timescale 1ns/1ps
interface fds_qual_if #(
  parameter int W = 16
);
  logic tick;
  logic cond;
  logic [W-1:0] limit;
  logic met;
  modport owner (output tick, output cond, output limit, input met);
  modport timer (input tick, input cond, input limit, output met);
endinterface

// >>> src/fds_settle.sv
// Millisecond settling-time qualifier
`timescale 1ns/1ps
module fds_settle #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  fds_qual_if.timer q
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  wire logic at_max = &count;

  generate
    if (W < 2) begin : g_chk
      $error("fds_settle: W must be at least 2");
    end
  endgenerate

  // Restart whenever the condition lapses, saturate at the top
  assign next_count = !q.cond ? '0 : (q.tick && !at_max) ? count + 1'b1 : count; // RL19
  assign q.met = q.cond && (count > q.limit); // RL19

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// >>> src/fds_status.sv
// Device status and flow warning evaluation with register port
//
// Summary of operation
// RL1: Flow valid bit follows sensor nominal state
// RL2: Temperature valid bit follows sensor state
// RL3: Zeroing bit high while zero runs
// RL4: Zero recommended after power-on interval elapses
// RL5: Success means no bad-zero or drift warning
// RL6: Zero recommended when idle flow drifts
// RL7: Zero recommended clears only on success
// RL8: Zero blocked bit and refused zero requests
// RL9: Valve override bit when override not normal
// RL10: Control override bit when control overridden
// RL11: Error, alarm, warning summary bits
// RL12: Button disable setting mirrored in bit 11
// RL13: Ramping bit while moving to setpoint
// RL14: Low flow warning with settle and hysteresis
// RL15: High flow warning with settle and hysteresis
// RL16: Choked warning disabled under four conditions
// RL17: Choked warning from flow and valve position
// RL18: Mask bit zero suppresses alarm or warning
// RL19: Settle counters restart when condition lapses
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module fds_status
  import fds_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic flow_ok,
  input wire logic temp_ok,
  input wire logic zero_busy,
  input wire logic zero_done,
  input wire logic zero_req,
  output logic zero_start,
  input wire logic signed [15:0] flow,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] ramp_setpoint,
  input wire logic [15:0] valve_pos,
  input wire logic [1:0] valve_override,
  input wire logic [1:0] ctrl_override,
  input wire logic safe_state,
  input wire logic safe_valve_closed,
  input wire logic [31:0] error_word,
  input wire logic [31:0] alarm_raw,
  input wire logic [31:0] warn_raw,
  output logic [31:0] device_condition_word,
  output logic [31:0] warning_condition_word,
  output logic zero_blocked,
  output logic irq
);
  generate
    if (MS_CYCLES < 1) begin : g_chk
      $error("fds_status: MS_CYCLES must be at least 1");
    end
  endgenerate

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Configuration and interrupt registers
  logic [31:0] alarm_mask;
  logic [31:0] warn_mask;
  logic signed [15:0] flow_lower_trip;
  logic signed [15:0] flow_upper_trip;
  logic [15:0] flow_hyst;
  logic [15:0] flow_settle;
  logic [15:0] zrec_time;
  logic [15:0] ztol_settle;
  logic [15:0] ztol_band;
  logic [CHOKE_LIM_FRAC-1:0] choke_lim;
  logic [15:0] choke_settle;
  logic [15:0] valve_max;
  logic btn_disable;
  logic [15:0] ramp_time;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  // Time base
  logic [$clog2(MS_CYCLES+1)-1:0] ms_div;
  logic [9:0] sec_div;
  wire logic ms_tick = (ms_div == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
  wire logic sec_tick = ms_tick && (sec_div == 10'(SEC_MS - 1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ms_div <= '0;
      sec_div <= '0;
    end else begin
      ms_div <= ms_tick ? '0 : ms_div + 1'b1;
      sec_div <= sec_tick ? '0 : ms_tick ? sec_div + 1'b1 : sec_div;
    end
  end

  // Register writes
  wire logic we_amask = reg_wr && hit(reg_addr, OFF_ALARM_MASK);
  wire logic we_wmask = reg_wr && hit(reg_addr, OFF_WARN_MASK);
  wire logic we_lo = reg_wr && hit(reg_addr, OFF_LOWER_TRIP);
  wire logic we_hi = reg_wr && hit(reg_addr, OFF_UPPER_TRIP);
  wire logic we_hyst = reg_wr && hit(reg_addr, OFF_FLOW_HYST);
  wire logic we_fset = reg_wr && hit(reg_addr, OFF_FLOW_SETTLE);
  wire logic we_zrec = reg_wr && hit(reg_addr, OFF_ZREC_TIME);
  wire logic we_ztset = reg_wr && hit(reg_addr, OFF_ZTOL_SETTLE);
  wire logic we_ztband = reg_wr && hit(reg_addr, OFF_ZTOL_BAND);
  wire logic we_clim = reg_wr && hit(reg_addr, OFF_CHOKE_LIM);
  wire logic we_cset = reg_wr && hit(reg_addr, OFF_CHOKE_SETTLE);
  wire logic we_vmax = reg_wr && hit(reg_addr, OFF_VALVE_MAX);
  wire logic we_ctrl = reg_wr && hit(reg_addr, OFF_CTRL);
  wire logic we_ramp = reg_wr && hit(reg_addr, OFF_RAMP_TIME);
  wire logic we_istat = reg_wr && hit(reg_addr, OFF_IRQ_STATUS);
  wire logic we_imask = reg_wr && hit(reg_addr, OFF_IRQ_MASK);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_mask <= MASK_RST;
      warn_mask <= MASK_RST;
      flow_lower_trip <= CFG16_RST;
      flow_upper_trip <= CFG16_RST;
      flow_hyst <= CFG16_RST;
      flow_settle <= CFG16_RST;
      zrec_time <= CFG16_RST;
      ztol_settle <= CFG16_RST;
      ztol_band <= CFG16_RST;
      choke_lim <= '0;
      choke_settle <= CFG16_RST;
      valve_max <= VALVE_MAX_RST;
      btn_disable <= 1'b0;
      ramp_time <= CFG16_RST;
      irq_mask <= IRQ_RST;
    end else begin
      if (we_amask) alarm_mask <= reg_wdata;
      if (we_wmask) warn_mask <= reg_wdata;
      if (we_lo) flow_lower_trip <= reg_wdata[15:0];
      if (we_hi) flow_upper_trip <= reg_wdata[15:0];
      if (we_hyst) flow_hyst <= reg_wdata[15:0];
      if (we_fset) flow_settle <= reg_wdata[15:0];
      if (we_zrec) zrec_time <= reg_wdata[15:0];
      if (we_ztset) ztol_settle <= reg_wdata[15:0];
      if (we_ztband) ztol_band <= reg_wdata[15:0];
      if (we_clim) choke_lim <= reg_wdata[CHOKE_LIM_FRAC-1:0];
      if (we_cset) choke_settle <= reg_wdata[15:0];
      if (we_vmax) valve_max <= reg_wdata[15:0];
      if (we_ctrl) btn_disable <= reg_wdata[CTRL_BTN_DIS];
      if (we_ramp) ramp_time <= reg_wdata[15:0];
      if (we_imask) irq_mask <= reg_wdata[3:0];
    end
  end

  // Masked alarm view and summaries
  wire logic [31:0] alarm_act = alarm_raw & alarm_mask; // RL18
  wire logic any_error = |error_word;
  wire logic any_alarm = |alarm_act;

  // Settle qualifiers
  fds_qual_if #(.W(MS_CNT_W)) qif [NUM_Q] ();
  logic [NUM_Q-1:0] q_cond;
  logic [NUM_Q-1:0] q_met;
  logic [MS_CNT_W-1:0] q_limit [NUM_Q];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_Q; gi++) begin : g_q
      assign qif[gi].tick = ms_tick;
      assign qif[gi].cond = q_cond[gi];
      assign qif[gi].limit = q_limit[gi];
      assign q_met[gi] = qif[gi].met;
      fds_settle #(.W(MS_CNT_W)) u_settle (
        .clk_sys(clk_sys),
        .rst(rst),
        .q(qif[gi])
      );
    end
  endgenerate

  // Flow trip comparisons with hysteresis
  wire logic signed [16:0] flow_x = 17'(flow);
  wire logic signed [16:0] lo_clr_lvl = 17'(flow_lower_trip) + $signed({1'b0, flow_hyst});
  wire logic signed [16:0] hi_clr_lvl = 17'(flow_upper_trip) - $signed({1'b0, flow_hyst});
  assign q_cond[Q_LOW_SET] = flow_ok && (flow < flow_lower_trip); // RL14
  assign q_cond[Q_LOW_CLR] = flow_ok && (flow_x > lo_clr_lvl); // RL14
  assign q_cond[Q_HIGH_SET] = flow_ok && (flow > flow_upper_trip); // RL15
  assign q_cond[Q_HIGH_CLR] = flow_ok && (flow_x < hi_clr_lvl); // RL15
  assign q_limit[Q_LOW_SET] = flow_settle;
  assign q_limit[Q_LOW_CLR] = flow_settle;
  assign q_limit[Q_HIGH_SET] = flow_settle;
  assign q_limit[Q_HIGH_CLR] = flow_settle;

  // Choked flow: flow below limit fraction of setpoint, valve above 70 %
  wire logic signed [25:0] flow_scaled = 26'(flow) <<< CHOKE_LIM_FRAC;
  wire logic [23:0] lim_prod = choke_lim * setpoint;
  wire logic [19:0] valve_scaled = 20'(valve_pos) * 20'(CHOKE_DEN);
  wire logic [19:0] valve_lvl = 20'(valve_max) * 20'(CHOKE_VALVE_NUM);
  wire logic [19:0] choke_ms_x = 20'(choke_settle) * 20'(CHOKE_TIME_NUM);
  wire logic choke_off = !flow_ok || alarm_raw[AL_CHOKED] || (setpoint == 16'h0000)
    || (valve_override == VO_OFF); // RL16
  wire logic choke_cond = (flow_scaled < $signed({2'b00, lim_prod}))
    && (valve_scaled > valve_lvl); // RL17
  assign q_cond[Q_CHOKE] = !choke_off && choke_cond; // RL17
  assign q_limit[Q_CHOKE] = 16'(choke_ms_x / 20'(CHOKE_DEN)); // RL17

  // Zero out of tolerance
  assign q_cond[Q_ZERO_SP] = (setpoint == 16'h0000); // RL6
  assign q_limit[Q_ZERO_SP] = ztol_settle;
  wire logic [15:0] flow_abs = flow[15] ? 16'(-flow) : 16'(flow);
  wire logic zero_tol_hit = (ztol_band != 16'h0000) && q_met[Q_ZERO_SP]
    && ({flow_abs, 1'b0} > {1'b0, ztol_band}); // RL6

  // Warning bits
  logic warn_low;
  logic warn_high;
  logic warn_choke;
  wire logic next_warn_low = !flow_ok ? 1'b0 : q_met[Q_LOW_SET] ? 1'b1
    : q_met[Q_LOW_CLR] ? 1'b0 : warn_low; // RL14
  wire logic next_warn_high = !flow_ok ? 1'b0 : q_met[Q_HIGH_SET] ? 1'b1
    : q_met[Q_HIGH_CLR] ? 1'b0 : warn_high; // RL15
  wire logic next_warn_choke = q_met[Q_CHOKE]; // RL17

  // Zero recommended: power-on seconds since last success
  logic [15:0] since_zero;
  logic zero_rec;
  wire logic zero_ok = zero_done && !warn_raw[WN_BAD_ZERO] && !warn_raw[WN_ZERO_DRIFT]; // RL5
  wire logic zero_age_hit = (zrec_time != 16'h0000) && (since_zero > zrec_time); // RL4
  wire logic next_zero_rec = zero_ok ? 1'b0 : (zero_age_hit || zero_tol_hit) ? 1'b1
    : zero_rec; // RL7

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      warn_low <= 1'b0;
      warn_high <= 1'b0;
      warn_choke <= 1'b0;
      since_zero <= 16'h0000;
      zero_rec <= 1'b0;
    end else begin
      warn_low <= next_warn_low;
      warn_high <= next_warn_high;
      warn_choke <= next_warn_choke;
      if (zero_ok) begin
        since_zero <= 16'h0000; // RL4
      end else if (sec_tick && !(&since_zero)) begin
        since_zero <= since_zero + 16'h0001; // RL4
      end
      zero_rec <= next_zero_rec;
    end
  end

  // Ramp tracking
  fds_ramp_type ramp_state;
  fds_ramp_type next_ramp_state;
  logic [15:0] setpoint_prev;
  wire logic sp_changed = (setpoint != setpoint_prev);

  always_comb begin
    next_ramp_state = ramp_state;
    case (ramp_state)
      RAMP_IDLE: begin
        if (sp_changed && ramp_time != 16'h0000) next_ramp_state = RAMP_MOVING; // RL13
      end
      RAMP_MOVING: begin
        if (ramp_time == 16'h0000 || ramp_setpoint == setpoint) begin
          next_ramp_state = RAMP_IDLE; // RL13
        end
      end
      default: next_ramp_state = RAMP_IDLE;
    endcase
  end

  // Zero inhibit
  wire logic vo_bad = (valve_override != VO_NORMAL) && (valve_override != VO_CLOSED);
  wire logic next_zero_blocked = (setpoint != 16'h0000) || vo_bad
    || (safe_state && !safe_valve_closed) || any_alarm || any_error; // RL8

  // Composed words
  logic [31:0] next_warn_word;
  logic [31:0] next_dev_word;
  always_comb begin
    next_warn_word = warn_raw;
    next_warn_word[WN_LOW_FLOW] = next_warn_low;
    next_warn_word[WN_HIGH_FLOW] = next_warn_high;
    next_warn_word[WN_CHOKED] = next_warn_choke;
    next_warn_word = next_warn_word & warn_mask; // RL18
    next_dev_word = 32'h00000000;
    next_dev_word[DS_FLOW_VALID] = flow_ok; // RL1
    next_dev_word[DS_TEMP_VALID] = temp_ok; // RL2
    next_dev_word[DS_ZEROING] = zero_busy; // RL3
    next_dev_word[DS_ZERO_REC] = next_zero_rec; // RL4
    next_dev_word[DS_ZERO_BLOCKED] = next_zero_blocked; // RL8
    next_dev_word[DS_VALVE_OVR] = (valve_override != VO_NORMAL); // RL9
    next_dev_word[DS_CTRL_OVR] = (ctrl_override != CO_NORMAL); // RL10
    next_dev_word[DS_ERROR] = any_error; // RL11
    next_dev_word[DS_ALARM] = any_alarm; // RL11
    next_dev_word[DS_WARNING] = |next_warn_word; // RL11
    next_dev_word[DS_BTN_DIS] = btn_disable; // RL12
    next_dev_word[DS_RAMPING] = (next_ramp_state == RAMP_MOVING); // RL13
  end

  // Interrupt events on warning and recommendation rising edges
  wire logic [3:0] irq_event = {next_zero_rec && !zero_rec, next_warn_choke && !warn_choke,
    next_warn_high && !warn_high, next_warn_low && !warn_low};
  wire logic [3:0] irq_clr = we_istat ? reg_wdata[3:0] : 4'h0;
  wire logic [3:0] next_irq_status = (irq_status & ~irq_clr) | irq_event;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ramp_state <= RAMP_IDLE;
      setpoint_prev <= 16'h0000;
      device_condition_word <= 32'h00000000;
      warning_condition_word <= 32'h00000000;
      zero_blocked <= 1'b1;
      zero_start <= 1'b0;
      irq_status <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      ramp_state <= next_ramp_state;
      setpoint_prev <= setpoint;
      device_condition_word <= next_dev_word;
      warning_condition_word <= next_warn_word;
      zero_blocked <= next_zero_blocked;
      zero_start <= zero_req && !next_zero_blocked; // RL8
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Register read, data one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFF_DEV_COND: rd_mux = device_condition_word;
      OFF_WARN_COND: rd_mux = warning_condition_word;
      OFF_ALARM_ACT: rd_mux = alarm_act;
      OFF_ERROR_ACT: rd_mux = error_word;
      OFF_ALARM_MASK: rd_mux = alarm_mask;
      OFF_WARN_MASK: rd_mux = warn_mask;
      OFF_LOWER_TRIP: rd_mux = {16'h0000, flow_lower_trip};
      OFF_UPPER_TRIP: rd_mux = {16'h0000, flow_upper_trip};
      OFF_FLOW_HYST: rd_mux = {16'h0000, flow_hyst};
      OFF_FLOW_SETTLE: rd_mux = {16'h0000, flow_settle};
      OFF_ZREC_TIME: rd_mux = {16'h0000, zrec_time};
      OFF_ZTOL_SETTLE: rd_mux = {16'h0000, ztol_settle};
      OFF_ZTOL_BAND: rd_mux = {16'h0000, ztol_band};
      OFF_CHOKE_LIM: rd_mux = {24'h000000, choke_lim};
      OFF_CHOKE_SETTLE: rd_mux = {16'h0000, choke_settle};
      OFF_VALVE_MAX: rd_mux = {16'h0000, valve_max};
      OFF_CTRL: rd_mux = {31'h00000000, btn_disable};
      OFF_RAMP_TIME: rd_mux = {16'h0000, ramp_time};
      OFF_IRQ_STATUS: rd_mux = {28'h0000000, irq_status};
      OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule

// >>> verification/fds_status_monitor.sv
// Port checker of the status block
`timescale 1ns/1ps
module fds_status_monitor
  import fds_pkg::*;
(
  input logic clk_sys,
  input logic rst,
  input logic flow_ok,
  input logic temp_ok,
  input logic zero_busy,
  input logic zero_done,
  input logic zero_req,
  input logic zero_start,
  input logic [15:0] setpoint,
  input logic [1:0] valve_override,
  input logic [1:0] ctrl_override,
  input logic [31:0] error_word,
  input logic [31:0] alarm_raw,
  input logic [31:0] warn_raw,
  input logic [31:0] device_condition_word,
  input logic [31:0] warning_condition_word,
  input logic zero_blocked
);
  wire [31:0] dw = device_condition_word;
  wire [31:0] ww = warning_condition_word;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_flow_valid;
    !$past(rst) |-> dw[DS_FLOW_VALID] == $past(flow_ok);
  endproperty
  a_flow_valid: assert property (p_flow_valid) else $error("flow valid");
  property p_flow_warn_off;
    !flow_ok |=> ww[1:0] == 2'h0 && !ww[WN_CHOKED];
  endproperty
  a_flow_warn_off: assert property (p_flow_warn_off) else $error("flow warning on");
  property p_temp_valid;
    !$past(rst) |-> dw[DS_TEMP_VALID] == $past(temp_ok);
  endproperty
  a_temp_valid: assert property (p_temp_valid) else $error("temp valid");
  property p_zeroing;
    !$past(rst) |-> dw[DS_ZEROING] == $past(zero_busy);
  endproperty
  a_zeroing: assert property (p_zeroing) else $error("zeroing bit");
  property p_overrides;
    !$past(rst) |-> dw[7:6] == {$past(ctrl_override) != 2'h0, $past(valve_override) != 2'h0};
  endproperty
  a_overrides: assert property (p_overrides) else $error("override bits");
  property p_error_sum;
    !$past(rst) |-> dw[DS_ERROR] == ($past(error_word) != 32'h0);
  endproperty
  a_error_sum: assert property (p_error_sum) else $error("error summary");
  property p_blocked;
    setpoint != 16'h0 || error_word != 32'h0 |=> zero_blocked && dw[DS_ZERO_BLOCKED];
  endproperty
  a_blocked: assert property (p_blocked) else $error("zero not blocked");
  property p_no_start;
    zero_req && setpoint != 16'h0 |=> !zero_start;
  endproperty
  a_no_start: assert property (p_no_start) else $error("zero started");
  property p_rec_clear;
    $fell(dw[DS_ZERO_REC]) |-> $past(zero_done) && $past(warn_raw[5:4]) == 2'h0;
  endproperty
  a_rec_clear: assert property (p_rec_clear) else $error("zero advice cleared");
  property p_choke_off;
    alarm_raw[AL_CHOKED] || setpoint == 16'h0 || valve_override == VO_OFF |=> !ww[WN_CHOKED];
  endproperty
  a_choke_off: assert property (p_choke_off) else $error("choked warning on");
  c_start: cover property (zero_req ##1 zero_start);
  c_low: cover property ($rose(ww[WN_LOW_FLOW]));
  c_rec: cover property ($rose(dw[DS_ZERO_REC]));
endmodule

bind fds_status fds_status_monitor u_mon (.*);

// >>> verification/fds_host.sv
// Register bus host model of the status block
`timescale 1ns/1ps
module fds_host (
  input logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input logic [31:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> verification/fds_status_tb.sv
// Self-checking bench of the status block
`timescale 1ns/1ps
module fds_status_tb
  import fds_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fok = 1'b1, tok = 1'b1, zbusy = 1'b0, zdone = 1'b0, zreq = 1'b0, safe = 1'b0;
  logic signed [15:0] flow = 16'sh0000;
  logic [15:0] sp = 16'h0000, rsp = 16'h0000, vpos = 16'h0000;
  logic [1:0] vo = 2'h0, co = 2'h0;
  logic [31:0] err = 32'h0, alm = 32'h0, wrn = 32'h0;
  logic [31:0] reg_rdata, dw, ww, reg_wdata;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, zstart, zblk, irq, svc = 1'b0;
  int err_total = 0, n_tests = 0;
  always #20 clk_sys = ~clk_sys;
  fds_host host (.*);
  fds_status #(.MS_CYCLES(4)) dut (.*, .flow_ok(fok), .temp_ok(tok), .zero_busy(zbusy),
    .zero_done(zdone), .zero_req(zreq), .zero_start(zstart), .setpoint(sp),
    .ramp_setpoint(rsp), .valve_pos(vpos), .valve_override(vo), .ctrl_override(co),
    .safe_state(safe), .safe_valve_closed(svc), .error_word(err), .alarm_raw(alm),
    .warn_raw(wrn), .device_condition_word(dw), .warning_condition_word(ww),
    .zero_blocked(zblk));
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    check(n, d, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic pick(input bit w, input int b);
    return w ? ww[b] : dw[b];
  endfunction
  task automatic wait_for(input bit w, input int b, input logic v, input int n);
    for (int i = 0; i < n && pick(w, b) !== v; i++) begin
      @(posedge clk_sys);
    end
    #1;
    check(w ? "warning bit" : "device bit", 32'(pick(w, b)), 32'(v));
  endtask
  task automatic zpulse(input logic e);
    @(posedge clk_sys);
    zreq <= 1'b1;
    @(posedge clk_sys);
    zreq <= 1'b0;
    #1;
    check("zero start", 32'(zstart), 32'(e));
  endtask
  task automatic zend(input logic [31:0] w);
    @(posedge clk_sys);
    zdone <= 1'b1;
    wrn <= w;
    @(posedge clk_sys);
    zdone <= 1'b0;
    wrn <= 32'h0;
    settle();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #800000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rchk("warn mask", OFF_WARN_MASK, MASK_RST);
    rchk("valve max", OFF_VALVE_MAX, {16'h0, VALVE_MAX_RST});
    rchk("irq status", OFF_IRQ_STATUS, 32'h0);
    rchk("unmapped", 8'h50, 32'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {zbusy, tok, fok} <= 3'(k);
      settle();
      check("sensor bits", {29'h0, dw[3:1]}, 32'(k));
    end
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys);
      vo <= 2'(v);
      co <= 2'(3 - v);
      settle();
      check("override bits", {30'h0, dw[7:6]}, {30'h0, v != 3, v != 0});
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      sp <= {15'h0, i == 0};
      vo <= (i == 1) ? VO_PURGE : (i == 2) ? VO_CLOSED : VO_NORMAL;
      {svc, safe} <= {i == 6, i == 3 || i == 6};
      alm <= {31'h0, i == 4};
      err <= {29'h0, i == 5, 2'h0};
      settle();
      check("zero blocked", 32'(zblk), 32'(i % 4 != 2));
      check("summary bits", {30'h0, dw[9:8]}, {30'h0, i == 4, i == 5});
      zpulse(i % 4 == 2);
    end
    @(posedge clk_sys);
    err <= 32'h0;
    host.wr(OFF_UPPER_TRIP, 32'd3000);
    host.wr(OFF_FLOW_HYST, 32'd10);
    host.wr(OFF_FLOW_SETTLE, 32'd2);
    host.wr(OFF_IRQ_MASK, 32'h1);
    host.wr(OFF_LOWER_TRIP, 32'd100);
    @(posedge clk_sys);
    flow <= 16'sd50;
    repeat (6) @(posedge clk_sys);
    wait_for(1, WN_LOW_FLOW, 1'b0, 0);
    wait_for(1, WN_LOW_FLOW, 1'b1, 40);
    settle();
    check("warning summary", 32'(dw[DS_WARNING]), 32'h1);
    check("irq", 32'(irq), 32'h1);
    rchk("irq status", OFF_IRQ_STATUS, 32'h1);
    host.wr(OFF_IRQ_STATUS, 32'h1);
    settle();
    check("irq", 32'(irq), 32'h0);
    host.wr(OFF_WARN_MASK, 32'hFFFFFFFE);
    settle();
    check("masked warning", {ww[0], dw[DS_WARNING]}, 2'h0);
    host.wr(OFF_WARN_MASK, MASK_RST);
    @(posedge clk_sys);
    flow <= 16'sd105;
    repeat (30) @(posedge clk_sys);
    wait_for(1, WN_LOW_FLOW, 1'b1, 0);
    flow <= 16'sd120;
    repeat (6) @(posedge clk_sys);
    flow <= 16'sd50;
    @(posedge clk_sys);
    flow <= 16'sd120;
    repeat (6) @(posedge clk_sys);
    wait_for(1, WN_LOW_FLOW, 1'b1, 0);
    wait_for(1, WN_LOW_FLOW, 1'b0, 40);
    @(posedge clk_sys);
    flow <= 16'sd4000;
    wait_for(1, WN_HIGH_FLOW, 1'b1, 40);
    @(posedge clk_sys);
    fok <= 1'b0;
    settle();
    check("invalid flow", {dw[DS_FLOW_VALID], ww[WN_HIGH_FLOW]}, 2'h0);
    @(posedge clk_sys);
    fok <= 1'b1;
    flow <= 16'sd100;
    sp <= 16'd1000;
    host.wr(OFF_CHOKE_LIM, 32'd128);
    host.wr(OFF_CHOKE_SETTLE, 32'd10);
    wait_for(1, WN_HIGH_FLOW, 1'b0, 40);
    @(posedge clk_sys);
    vpos <= 16'hFFFF;
    repeat (10) @(posedge clk_sys);
    wait_for(1, WN_CHOKED, 1'b0, 0);
    wait_for(1, WN_CHOKED, 1'b1, 40);
    @(posedge clk_sys);
    alm <= 32'h8;
    wait_for(1, WN_CHOKED, 1'b0, 2);
    @(posedge clk_sys);
    alm <= 32'h0;
    wait_for(1, WN_CHOKED, 1'b1, 40);
    @(posedge clk_sys);
    vpos <= 16'h8000;
    wait_for(1, WN_CHOKED, 1'b0, 2);
    host.wr(OFF_RAMP_TIME, 32'd5);
    @(posedge clk_sys);
    sp <= 16'd2000;
    wait_for(0, DS_RAMPING, 1'b1, 4);
    @(posedge clk_sys);
    rsp <= 16'd2000;
    wait_for(0, DS_RAMPING, 1'b0, 4);
    host.wr(OFF_CTRL, 32'h1);
    wait_for(0, DS_BTN_DIS, 1'b1, 4);
    host.wr(OFF_CTRL, 32'h0);
    wait_for(0, DS_BTN_DIS, 1'b0, 4);
    host.wr(OFF_ZTOL_BAND, 32'd100);
    host.wr(OFF_ZTOL_SETTLE, 32'd2);
    @(posedge clk_sys);
    sp <= 16'h0000;
    flow <= 16'sd60;
    wait_for(0, DS_ZERO_REC, 1'b1, 40);
    @(posedge clk_sys);
    flow <= 16'sd0;
    zend(32'h20);
    wait_for(0, DS_ZERO_REC, 1'b1, 0);
    zend(32'h0);
    wait_for(0, DS_ZERO_REC, 1'b0, 0);
    host.wr(OFF_ZTOL_BAND, 32'd0);
    host.wr(OFF_ZREC_TIME, 32'd1);
    zend(32'h0);
    repeat (3900) @(posedge clk_sys);
    wait_for(0, DS_ZERO_REC, 1'b0, 0);
    wait_for(0, DS_ZERO_REC, 1'b1, 4200);
    tally_and_finish();
  end
endmodule
